/* File: shared/spt_defs.svh */
// Purpose: constants of the sector protect and training pattern registers
// Assumes: 256 uniform sectors, byte wide access registers
// Notes:   definitions only
`ifndef SPT_DEFS_SVH
`define SPT_DEFS_SVH

`define SPT_SECTORS        256
`define SPT_SECTOR_W       8
`define SPT_ACC_PROTECT    8'h00
`define SPT_ACC_OPEN       8'hFF
`define SPT_PERS_RESET     1'b1
`define SPT_DYN_RESET      1'b1
`define SPT_LOCK_RSV_RESET 7'h00
`define SPT_NVP_RESET      8'h00
`define SPT_ADVP_MODEL_A   16'hFE7F
`define SPT_ADVP_MODEL_B   16'hFE4F
`define SPT_ADVP_PWD_BIT   2
`define SPT_ARRAY_ERASED   8'hFF
`define SPT_OTP_RANDOM_LEN 16
`define SPT_OTP_ERASED     8'hFF
`define SPT_STAT1_FACTORY  8'h00
`define SPT_CR1_FACTORY    8'h00
`define SPT_AB_FACTORY     8'h00
`define SPT_SEL_STAT1      10'h000
`define SPT_SEL_CR1        10'h001
`define SPT_SEL_AB         10'h002

`endif

/* File: shared/spt_pkg.sv */
// Purpose: types shared by the sector protect and training pattern block
// Assumes: spt_defs.svh constants
// Notes:   command and answer carriers
package spt_pkg;

    typedef enum logic [3:0] {
        SPT_NOP      = 4'h0,
        SPT_PERS_RD  = 4'h1,
        SPT_PERS_PGM = 4'h2,
        SPT_PERS_ERS = 4'h3,
        SPT_DYN_RD   = 4'h4,
        SPT_DYN_WR   = 4'h5,
        SPT_LOCK_RD  = 4'h6,
        SPT_LOCK_WR  = 4'h7,
        SPT_NVP_RD   = 4'h8,
        SPT_NVP_PGM  = 4'h9,
        SPT_VP_RD    = 4'hA,
        SPT_VP_WR    = 4'hB,
        SPT_ASP_RD   = 4'hC,
        SPT_ASP_PGM  = 4'hD,
        SPT_OTP_RD   = 4'hE,
        SPT_FACT_RD  = 4'hF
    } spt_op_e;

    typedef struct packed {
        logic          valid;
        spt_op_e       op;
        logic [7:0]    sector;
        logic [9:0]    addr;
        logic [15:0]   wdata;
    } spt_cmd_s;

    typedef struct packed {
        logic          valid;
        logic          err;
        logic [15:0]   rdata;
    } spt_resp_s;

endpackage : spt_pkg

/* File: src/spt_sector_bits.sv */
// Purpose: per sector persistent and dynamic protection bits
// Assumes: one sector addressed per cycle
// Notes:   persistent bits survive RST, only nv_rst restores them
`timescale 1ns/100ps
`include "spt_defs.svh"
module spt_sector_bits (
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic                      nv_rst,
    input  wire logic [`SPT_SECTOR_W-1:0]  sector,
    input  wire logic                      pers_pgm,
    input  wire logic                      pers_ers,
    input  wire logic                      dyn_wr,
    input  wire logic                      dyn_val,
    output logic      [`SPT_SECTORS-1:0]   pers_v,
    output logic      [`SPT_SECTORS-1:0]   dyn_v
);

    genvar g;
    generate
        for (g = 0; g < `SPT_SECTORS; g = g + 1) begin : g_sec
            wire hit = (sector == (`SPT_SECTOR_W)'(g));
            // bulk erase reopens every sector at once
            always_ff @(posedge clk or posedge nv_rst) begin
                if (nv_rst) begin
                    pers_v[g] <= `SPT_PERS_RESET;
                end else if (pers_ers) begin
                    pers_v[g] <= 1'b1;
                end else if (pers_pgm && hit) begin
                    pers_v[g] <= 1'b0;
                end
            end
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    dyn_v[g] <= `SPT_DYN_RESET;
                end else if (dyn_wr && hit) begin
                    dyn_v[g] <= dyn_val;
                end
            end
        end
    endgenerate

endmodule : spt_sector_bits

/* File: src/spt_regs.sv */
// Purpose: sector protect bits, array lock and training pattern registers
// Assumes: commands come from logic on CLK_SYS; NV_RST marks factory state
// Notes:   one answer per command, one cycle after it
`timescale 1ns/100ps
`include "spt_defs.svh"
module spt_regs #(
    parameter logic [15:0]  ADVP_FACTORY = `SPT_ADVP_MODEL_A,
    parameter logic [127:0] OTP_RANDOM   = 128'h5A3C_96E1_0F87_D24B_1E69_C3A5_7B20_E4D8
) (
    input  wire logic              CLK_SYS,
    input  wire logic              RST,
    input  wire logic              NV_RST,
    input  wire spt_pkg::spt_cmd_s CMD,
    input  wire logic [7:0]        PROT_SECTOR,
    input  wire logic              PATTERN_EN,
    output spt_pkg::spt_resp_s     RESP,
    output logic                   PROT_BLOCKED,
    output logic                   LOCK_STATE,
    output logic                   PATTERN_DRIVE,
    output logic [7:0]             PATTERN_OUT
);

    logic                     lock_q;
    logic                     init_q;
    logic [7:0]               nvp_q;
    logic                     nvp_used_q;
    logic [7:0]               vp_q;
    logic [15:0]              advp_q;
    logic [`SPT_SECTORS-1:0]  pers_v;
    logic [`SPT_SECTORS-1:0]  dyn_v;
    spt_pkg::spt_resp_s       resp_q;
    logic                     prot_q;
    logic                     pdrv_q;
    logic [7:0]               pout_q;

    wire [7:0] wd = CMD.wdata[7:0];
    wire       go = CMD.valid;
    wire       is_pers_rd  = go && (CMD.op == spt_pkg::SPT_PERS_RD);
    wire       is_pers_pgm = go && (CMD.op == spt_pkg::SPT_PERS_PGM);
    wire       is_pers_ers = go && (CMD.op == spt_pkg::SPT_PERS_ERS);
    wire       is_dyn_rd   = go && (CMD.op == spt_pkg::SPT_DYN_RD);
    wire       is_dyn_wr   = go && (CMD.op == spt_pkg::SPT_DYN_WR);
    wire       is_lock_rd = go && (CMD.op == spt_pkg::SPT_LOCK_RD);
    wire       is_lock_wr = go && (CMD.op == spt_pkg::SPT_LOCK_WR);
    wire       is_nvp_rd  = go && (CMD.op == spt_pkg::SPT_NVP_RD);
    wire       is_nvp_pgm = go && (CMD.op == spt_pkg::SPT_NVP_PGM);
    wire       is_vp_rd   = go && (CMD.op == spt_pkg::SPT_VP_RD);
    wire       is_vp_wr   = go && (CMD.op == spt_pkg::SPT_VP_WR);
    wire       is_asp_rd  = go && (CMD.op == spt_pkg::SPT_ASP_RD);
    wire       is_asp_pgm = go && (CMD.op == spt_pkg::SPT_ASP_PGM);
    wire       is_otp_rd  = go && (CMD.op == spt_pkg::SPT_OTP_RD);
    wire       is_fact_rd = go && (CMD.op == spt_pkg::SPT_FACT_RD);
    wire       is_nop     = go && (CMD.op == spt_pkg::SPT_NOP);

    wire pwd_mode  = ~advp_q[`SPT_ADVP_PWD_BIT];
    wire acc_legal = (wd == `SPT_ACC_PROTECT) || (wd == `SPT_ACC_OPEN);
    // persistent program only writes the protecting value; erase reopens all
    wire pers_pgm_go = is_pers_pgm && lock_q && (wd == `SPT_ACC_PROTECT);
    wire pers_ers_go = is_pers_ers && lock_q;
    wire dyn_wr_go   = is_dyn_wr && acc_legal && !init_q;
    wire nvp_pgm_go = is_nvp_pgm && !nvp_used_q;
    wire vp_wr_go   = is_vp_wr && !init_q;

    wire refused = (is_pers_pgm && !pers_pgm_go) || (is_pers_ers && !pers_ers_go)
                || (is_dyn_wr && !dyn_wr_go) || (is_nvp_pgm && !nvp_pgm_go)
                || (is_vp_wr && !vp_wr_go) || is_nop;

    // commands can only clear lock; RST clears it too, and it is set again only when advp_q bit 2 is set
    wire lock_d = init_q ? ~pwd_mode
                : (is_lock_wr && !wd[0]) ? 1'b0 : lock_q;

    wire [7:0] sel_pers = pers_v[CMD.sector] ? `SPT_ACC_OPEN : `SPT_ACC_PROTECT;
    wire [7:0] sel_dyn  = dyn_v[CMD.sector] ? `SPT_ACC_OPEN : `SPT_ACC_PROTECT;
    wire [7:0] sel_lock = {`SPT_LOCK_RSV_RESET, lock_q};
    wire       otp_rnd  = (CMD.addr < 10'(`SPT_OTP_RANDOM_LEN));
    wire [6:0] otp_bit  = {CMD.addr[3:0], 3'h0};
    wire [7:0] sel_otp  = otp_rnd ? OTP_RANDOM[otp_bit +: 8] : `SPT_OTP_ERASED;
    wire [7:0] sel_fact = (CMD.addr == `SPT_SEL_STAT1) ? `SPT_STAT1_FACTORY
                        : (CMD.addr == `SPT_SEL_CR1) ? `SPT_CR1_FACTORY
                        : (CMD.addr == `SPT_SEL_AB)  ? `SPT_AB_FACTORY
                        : `SPT_ARRAY_ERASED;
    wire [15:0] rd_data = is_pers_rd ? {8'h00, sel_pers}
                        : is_dyn_rd  ? {8'h00, sel_dyn}
                        : is_lock_rd ? {8'h00, sel_lock}
                        : is_nvp_rd  ? {8'h00, nvp_q}
                        : is_vp_rd   ? {8'h00, vp_q}
                        : is_asp_rd  ? advp_q
                        : is_otp_rd  ? {8'h00, sel_otp}
                        : is_fact_rd ? {8'h00, sel_fact}
                        : 16'h0000;

    wire blocked_d = ~pers_v[PROT_SECTOR] | ~dyn_v[PROT_SECTOR];

    spt_sector_bits u_spt_sector_bits (
        .clk      (CLK_SYS),
        .rst      (RST),
        .nv_rst   (NV_RST),
        .sector   (CMD.sector),
        .pers_pgm (pers_pgm_go),
        .pers_ers (pers_ers_go),
        .dyn_wr   (dyn_wr_go),
        .dyn_val  (wd[0]),
        .pers_v   (pers_v),
        .dyn_v    (dyn_v)
    );

    // nonvolatile state: survives RST, restored to factory by NV_RST
    always_ff @(posedge CLK_SYS or posedge NV_RST) begin
        if (NV_RST) begin
            nvp_q      <= `SPT_NVP_RESET;
            nvp_used_q <= 1'b0;
            advp_q     <= ADVP_FACTORY;
        end else begin
            if (nvp_pgm_go) begin
                nvp_q      <= wd;
                nvp_used_q <= 1'b1;
            end
            // otp bits only move from one to zero
            if (is_asp_pgm) begin
                advp_q <= advp_q & CMD.wdata;
            end
        end
    end

    // mode depends on advp_q, so lock and pattern load one cycle after release
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            init_q <= 1'b1;
            lock_q <= 1'b0;
            vp_q   <= `SPT_NVP_RESET;
        end else begin
            init_q <= 1'b0;
            lock_q <= lock_d;
            vp_q   <= init_q ? nvp_q : (vp_wr_go ? wd : vp_q);
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            resp_q <= '0;
            prot_q <= 1'b1;
            pdrv_q <= 1'b0;
            pout_q <= 8'h00;
        end else begin
            resp_q <= '{valid: go, err: refused, rdata: rd_data};
            prot_q <= blocked_d;
            pdrv_q <= PATTERN_EN;
            pout_q <= vp_q;
        end
    end

    assign RESP          = resp_q;
    assign PROT_BLOCKED  = prot_q;
    assign LOCK_STATE    = lock_q;
    assign PATTERN_DRIVE = pdrv_q;
    assign PATTERN_OUT   = pout_q;

    lock_refuse_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        (is_pers_pgm || is_pers_ers) && !lock_q |=> RESP.err && $stable(pers_v))
        else $error("persistent bits changed while locked");

    lock_init_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        init_q |=> (lock_q == advp_q[`SPT_ADVP_PWD_BIT]) && !init_q)
        else $error("lock bit wrong after reset");

    lock_rsv_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        is_lock_rd |=> RESP.valid && (RESP.rdata[7:1] == 7'h00))
        else $error("lock reserved bits not zero");

    pers_prog_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        pers_pgm_go && (PROT_SECTOR == CMD.sector)
        |=> !pers_v[$past(CMD.sector)] ##1 PROT_BLOCKED)
        else $error("persistent program did not protect");

    pers_erase_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        pers_ers_go |=> (&pers_v) && !RESP.err)
        else $error("persistent erase did not reopen sectors");

    dyn_clear_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        dyn_wr_go && (wd == `SPT_ACC_PROTECT) && (PROT_SECTOR == CMD.sector)
        |=> !dyn_v[$past(CMD.sector)] ##1 PROT_BLOCKED)
        else $error("dynamic clear did not protect");

    dyn_set_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        dyn_wr_go && (wd == `SPT_ACC_OPEN) |=> dyn_v[$past(CMD.sector)])
        else $error("dynamic set did not unprotect");

    vp_load_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        init_q |=> (vp_q == $past(nvp_q)) ##1 (PATTERN_OUT == $past(nvp_q, 2)))
        else $error("volatile pattern not loaded");

    pat_drive_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        PATTERN_EN |=> PATTERN_DRIVE && (PATTERN_OUT == $past(vp_q)))
        else $error("pattern not delivered");

    prot_map_a: assert property (@(posedge CLK_SYS) disable iff (RST)
        1'b1 |=> PROT_BLOCKED == $past(blocked_d))
        else $error("sector protect status wrong");

    cov_lock_refuse: cover property (@(posedge CLK_SYS) disable iff (RST)
        is_pers_pgm && !lock_q);
    cov_dyn_cycle: cover property (@(posedge CLK_SYS) disable iff (RST)
        (dyn_wr_go && !wd[0]) ##[1:20] (dyn_wr_go && wd[0]));
    cov_vp_write: cover property (@(posedge CLK_SYS) disable iff (RST)
        vp_wr_go ##1 PATTERN_EN);

endmodule : spt_regs

/* File: test/spt_host_model.sv */
// Purpose: host controller model issuing one command at a time
// Assumes: answer stands only in the cycle after the taking edge
// Notes:   idle cycles hold valid low and all fields zero
`timescale 1ns/100ps
module spt_host_model (
    input  wire logic               clk,
    input  wire spt_pkg::spt_resp_s resp,
    output spt_pkg::spt_cmd_s       cmd
);
    initial cmd = '0;

    // any op at any time, volatile pattern rewrites included
    task automatic xfer(input spt_pkg::spt_op_e op, input logic [7:0] sec,
                        input logic [9:0] addr, input logic [15:0] wd,
                        output spt_pkg::spt_resp_s r);
        @(posedge clk);
        #2;
        cmd = '{valid: 1'b1, op: op, sector: sec, addr: addr, wdata: wd};
        @(posedge clk);
        #2;
        cmd = '0;
        // answer is gone after the next edge, so take it now
        r = resp;
    endtask : xfer
endmodule : spt_host_model

/* File: test/sector_protect_training_regs_test.sv */
// Purpose: self-checking bench of the protect and pattern registers
// Assumes: host model drives CMD, bench drives query and pattern inputs
// Notes:   RST-only resets show which state survives a hardware reset
`timescale 1ns/100ps
module sector_protect_training_regs_test;
    localparam logic [127:0] OTP_V = 128'h1122_3344_5566_7788_99AA_BBCC_DDEE_F00F;
    logic               clk_sys, rst, nv_rst, pattern_en;
    logic               prot_blocked, lock_state, pattern_drive;
    logic [7:0]         prot_sector, pattern_out;
    spt_pkg::spt_cmd_s  cmd;
    spt_pkg::spt_resp_s resp;
    int                 err_total, n_checks;

    spt_regs #(.OTP_RANDOM(OTP_V)) u_spt_regs (.CLK_SYS(clk_sys), .RST(rst),
        .NV_RST(nv_rst), .CMD(cmd), .PROT_SECTOR(prot_sector), .PATTERN_EN(pattern_en),
        .RESP(resp), .PROT_BLOCKED(prot_blocked), .LOCK_STATE(lock_state),
        .PATTERN_DRIVE(pattern_drive), .PATTERN_OUT(pattern_out));
    spt_host_model u_spt_host_model (.clk(clk_sys), .resp(resp), .cmd(cmd));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic run(input spt_pkg::spt_op_e op, input logic [7:0] sec,
                       input logic [9:0] addr, input logic [15:0] wd,
                       input logic e_err, input logic [15:0] e_data);
        spt_pkg::spt_resp_s r;
        u_spt_host_model.xfer(op, sec, addr, wd, r);
        chk({r.valid, r.err, r.rdata}, {1'b1, e_err, e_data});
    endtask : run

    // registered query, so let two edges pass before looking
    task automatic blk(input logic exp);
        @(posedge clk_sys);
        @(posedge clk_sys);
        #2;
        chk({17'h0, prot_blocked}, {17'h0, exp});
    endtask : blk

    task automatic do_reset(input logic nv);
        rst = 1'b1;
        nv_rst = nv;
        repeat (16) @(posedge clk_sys);
        #2;
        rst = 1'b0;
        nv_rst = 1'b0;
        @(posedge clk_sys);
    endtask : do_reset

    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        $display("BAD t=%0t run did not finish", $time);
        stop_test();
    end

    initial begin
        rst = 1'b1;
        nv_rst = 1'b1;
        err_total = 0;
        n_checks = 0;
        pattern_en = 1'b1;
        prot_sector = 8'h07;
        do_reset(1'b1);
        run(spt_pkg::SPT_LOCK_RD, 0, 0, 0, 0, 16'h0001);
        run(spt_pkg::SPT_LOCK_WR, 0, 0, 16'h00FF, 0, 0);
        run(spt_pkg::SPT_LOCK_RD, 0, 0, 0, 0, 16'h0001);
        run(spt_pkg::SPT_PERS_RD, 7, 0, 0, 0, 16'h00FF);
        run(spt_pkg::SPT_DYN_RD, 7, 0, 0, 0, 16'h00FF);
        run(spt_pkg::SPT_NVP_RD, 0, 0, 0, 0, 16'h0000);
        run(spt_pkg::SPT_VP_RD, 0, 0, 0, 0, 16'h0000);
        blk(1'b0);
        run(spt_pkg::SPT_DYN_WR, 7, 0, 16'h0000, 0, 0);
        run(spt_pkg::SPT_DYN_RD, 7, 0, 0, 0, 16'h0000);
        blk(1'b1);
        run(spt_pkg::SPT_DYN_WR, 7, 0, 16'h005A, 1, 0);
        run(spt_pkg::SPT_DYN_WR, 7, 0, 16'h00FF, 0, 0);
        blk(1'b0);
        run(spt_pkg::SPT_DYN_WR, 3, 0, 16'h0000, 0, 0);
        run(spt_pkg::SPT_PERS_PGM, 7, 0, 16'h0012, 1, 0);
        run(spt_pkg::SPT_PERS_PGM, 7, 0, 16'h0000, 0, 0);
        run(spt_pkg::SPT_PERS_RD, 7, 0, 0, 0, 16'h0000);
        blk(1'b1);
        run(spt_pkg::SPT_PERS_ERS, 0, 0, 0, 0, 0);
        run(spt_pkg::SPT_PERS_RD, 7, 0, 0, 0, 16'h00FF);
        run(spt_pkg::SPT_PERS_PGM, 9, 0, 16'h0000, 0, 0);
        run(spt_pkg::SPT_LOCK_WR, 0, 0, 16'h0000, 0, 0);
        chk({17'h0, lock_state}, 18'h0);
        run(spt_pkg::SPT_PERS_PGM, 7, 0, 16'h0000, 1, 0);
        run(spt_pkg::SPT_PERS_ERS, 0, 0, 0, 1, 0);
        run(spt_pkg::SPT_PERS_RD, 9, 0, 0, 0, 16'h0000);
        run(spt_pkg::SPT_NVP_PGM, 0, 0, 16'h003C, 0, 0);
        run(spt_pkg::SPT_NVP_PGM, 0, 0, 16'h0055, 1, 0);
        run(spt_pkg::SPT_VP_WR, 0, 0, 16'h00A5, 0, 0);
        run(spt_pkg::SPT_VP_RD, 0, 0, 0, 0, 16'h00A5);
        @(posedge clk_sys);
        #2;
        chk({9'h0, pattern_drive, pattern_out}, {9'h0, 1'b1, 8'hA5});
        do_reset(1'b0);
        run(spt_pkg::SPT_LOCK_RD, 0, 0, 0, 0, 16'h0001);
        run(spt_pkg::SPT_PERS_RD, 9, 0, 0, 0, 16'h0000);
        run(spt_pkg::SPT_DYN_RD, 3, 0, 0, 0, 16'h00FF);
        run(spt_pkg::SPT_VP_RD, 0, 0, 0, 0, 16'h003C);
        // query other sectors: persistent bit kept, dynamic bit back to open
        prot_sector = 8'h09;
        blk(1'b1);
        prot_sector = 8'h03;
        blk(1'b0);
        prot_sector = 8'h07;
        pattern_en = 1'b0;
        @(posedge clk_sys);
        #2;
        chk({9'h0, pattern_drive, pattern_out}, {9'h0, 1'b0, 8'h3C});
        pattern_en = 1'b1;
        run(spt_pkg::SPT_ASP_RD, 0, 0, 0, 0, 16'hFE7F);
        for (int a = 0; a < 18; a++) begin
            if (a < 16) begin
                run(spt_pkg::SPT_OTP_RD, 0, a[9:0], 0, 0, {8'h0, OTP_V[8*a +: 8]});
            end else begin
                run(spt_pkg::SPT_OTP_RD, 0, a[9:0], 0, 0, 16'h00FF);
            end
        end
        run(spt_pkg::SPT_OTP_RD, 0, 10'h3FF, 0, 0, 16'h00FF);
        for (int a = 0; a < 4; a++) begin
            run(spt_pkg::SPT_FACT_RD, 0, a[9:0], 0, 0, (a < 3) ? 16'h0 : 16'hFF);
        end
        run(spt_pkg::SPT_ASP_PGM, 0, 0, 16'hFFFB, 0, 0);
        run(spt_pkg::SPT_ASP_RD, 0, 0, 0, 0, 16'hFE7B);
        do_reset(1'b0);
        run(spt_pkg::SPT_LOCK_RD, 0, 0, 0, 0, 16'h0000);
        chk({17'h0, lock_state}, 18'h0);
        stop_test();
    end
endmodule : sector_protect_training_regs_test
